/* File: src/gpio_cfg.svh */
// register indices, reset values and field positions of the port block
// assumes a 32-bit apb slave where byte address = index * 4
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH
// register indices
`define IDX_PORT_A   10'h005
`define IDX_PORT_B   10'h006
`define IDX_PORT_C   10'h007
`define IDX_INTCTL   10'h00B
`define IDX_OPTION   10'h081
`define IDX_DIR_A    10'h085
`define IDX_DIR_B    10'h086
`define IDX_DIR_C    10'h087
`define IDX_ANALOG   10'h09F
// reset values
`define RST_OPTION   8'hFF
`define RST_DIR_A    6'h3F
`define RST_DIR_B    8'hFF
`define RST_DIR_C    8'hFF
`define RST_ANALOG   8'h00
`define RST_LATCH    8'h00
`define ANALOG_WMASK 8'h8F
// field positions
`define OPT_PULLUP_N 7
`define OPT_EDGE     6
`define INT_FLAG     0
`define PA_TIMER     4
`define PB_EXT       0
`define PB_PGM       3
`define PB_PGC       6
`define PB_PGD       7
`define SMB_LO       3
`define SMB_HI       4
// analog pin masks over port a bits 5..0
`define AN_ALL       6'h2F
`define AN_013       6'h0B
`define AN_0         6'h01
`define AN_NONE      6'h00
`endif

/* File: src/gpio_pkg.sv */
// types shared by the three-port gpio block
// assumes gpio_cfg.svh holds the numeric constants
package gpio_pkg;
  // apb request bundle from the bus master
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // peripheral claims on port c, one bit per pin
  typedef struct packed {
    logic [7:0] sel;
    logic [7:0] dout;
    logic [7:0] oe;
  } periph_pin_t;

  // decoded register target
  typedef enum logic [3:0] {
    SEL_NONE   = 4'b0000,
    SEL_PA     = 4'b0001,
    SEL_PB     = 4'b0010,
    SEL_PC     = 4'b0011,
    SEL_INTCTL = 4'b0100,
    SEL_OPTION = 4'b0101,
    SEL_DIR_A  = 4'b0110,
    SEL_DIR_B  = 4'b0111,
    SEL_DIR_C  = 4'b1000,
    SEL_ANALOG = 4'b1001
  } reg_sel_t;
endpackage

/* File: src/gpio_three_port.sv */
// three-port gpio with change detect, pull-ups and peripheral override
// assumes an apb master on mclk_i and pins arriving asynchronously
`include "gpio_cfg.svh"

module gpio_three_port
  import gpio_pkg::*;
(
  input  wire logic        mclk_i,        // 40 mhz clock
  input  wire logic        arst_n_i,      // async reset, low
  input  wire apb_req_t    apb_i,         // apb request
  output logic [31:0]      prdata_o,      // apb read data
  output logic             pready_o,      // apb ready
  output logic             pslverr_o,     // unmapped address
  input  wire logic [5:0]  pa_in_i,       // port a pin levels
  output logic [5:0]       pa_out_o,      // port a drive value
  output logic [5:0]       pa_oe_n_o,     // port a enable, low drives
  input  wire logic [7:0]  pb_in_i,       // port b pin levels
  output logic [7:0]       pb_out_o,      // port b drive value
  output logic [7:0]       pb_oe_n_o,     // port b enable, low drives
  output logic [7:0]       pb_pullup_o,   // port b weak pull-up on
  input  wire logic [7:0]  pc_in_i,       // port c pin levels
  output logic [7:0]       pc_out_o,      // port c drive value
  output logic [7:0]       pc_oe_n_o,     // port c enable, low drives
  input  wire periph_pin_t pc_periph_i,   // peripheral claims on port c
  input  wire logic        i2c_en_i,      // two-wire module enabled
  input  wire logic        smbus_sel_i,   // serial status bit 6 value
  input  wire logic        lvp_en_i,      // low-voltage programming on
  output logic             smbus_lvl_o,   // port c bits 4,3 smbus levels
  output logic             timer_clk_o,   // synced timer clock pin
  output logic             ext_irq_o,     // synced external irq pin
  output logic             ext_edge_o,    // external irq edge select
  output logic             prog_mode_o,   // program-mode pin level
  output logic             prog_clock_o,  // programming clock level
  output logic             prog_data_o,   // programming data level
  output logic             wake_o         // port change wake request
);

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************

  logic        rst_meta_r;
  logic        rst_n_r;
  logic [21:0] pin_meta_r;
  logic [21:0] pin_sync_r;
  logic [5:0]  pa_sync;
  logic [7:0]  pb_sync;
  logic [7:0]  pc_sync;

  // release is delayed two edges; assertion stays asynchronous
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // two flops per pin; only the second stage is read
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 22'h000000;
      pin_sync_r <= 22'h000000;
    end else begin
      pin_meta_r <= {pc_in_i, pb_in_i, pa_in_i};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign pa_sync = pin_sync_r[5:0];
  assign pb_sync = pin_sync_r[13:6];
  assign pc_sync = pin_sync_r[21:14];

  // ****************************************
  // apb decode
  // ****************************************

  // index decode shared by read mux and write strobes
  function automatic reg_sel_t decode_sel(input logic [11:0] addr);
    logic [9:0] idx;
    idx = addr[11:2];
    if (addr[1:0] != 2'b00)      decode_sel = SEL_NONE;
    else if (idx == `IDX_PORT_A) decode_sel = SEL_PA;
    else if (idx == `IDX_PORT_B) decode_sel = SEL_PB;
    else if (idx == `IDX_PORT_C) decode_sel = SEL_PC;
    else if (idx == `IDX_INTCTL) decode_sel = SEL_INTCTL;
    else if (idx == `IDX_OPTION) decode_sel = SEL_OPTION;
    else if (idx == `IDX_DIR_A)  decode_sel = SEL_DIR_A;
    else if (idx == `IDX_DIR_B)  decode_sel = SEL_DIR_B;
    else if (idx == `IDX_DIR_C)  decode_sel = SEL_DIR_C;
    else if (idx == `IDX_ANALOG) decode_sel = SEL_ANALOG;
    else                         decode_sel = SEL_NONE;
  endfunction

  // analog field to port a analog-pin mask; bit 4 never analog
  function automatic logic [5:0] analog_mask(input logic [3:0] fld);
    if (fld[3:2] == 2'b00)    analog_mask = `AN_ALL;
    else if (fld[3:1] == 3'b011) analog_mask = `AN_NONE;
    else if (fld == 4'h4 || fld == 4'h5 || fld == 4'hD)
      analog_mask = `AN_013;
    else if (fld == 4'hF)     analog_mask = `AN_0;
    else                      analog_mask = `AN_ALL;
  endfunction

  reg_sel_t    sel;
  logic        setup;
  logic        acc;
  logic        wr;
  logic [7:0]  wd;
  logic        pready_r;

  // a transfer completes in the first access cycle
  assign sel   = decode_sel(apb_i.paddr);
  assign setup = apb_i.psel & ~apb_i.penable;
  assign acc   = apb_i.psel & apb_i.penable & pready_r;
  assign wr    = acc & apb_i.pwrite;
  assign wd    = apb_i.pwdata[7:0];

  // ****************************************
  // software registers
  // ****************************************

  logic [5:0] pa_lat_r;
  logic [7:0] pb_lat_r;
  logic [7:0] pc_lat_r;
  logic [5:0] dir_a_r;
  logic [7:0] dir_b_r;
  logic [7:0] dir_c_r;
  logic [7:0] opt_r;
  logic [7:0] an_r;
  logic       flag_r;
  logic       flag_nxt;
  logic [3:0] ref_r;
  logic       mismatch;
  logic [5:0] an_mask;

  // writes land in latches, never in pin state
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pa_lat_r <= 6'h00;
      pb_lat_r <= `RST_LATCH;
      pc_lat_r <= `RST_LATCH;
      dir_a_r  <= `RST_DIR_A;
      dir_b_r  <= `RST_DIR_B;
      dir_c_r  <= `RST_DIR_C;
      opt_r    <= `RST_OPTION;
      an_r     <= `RST_ANALOG;
    end else if (wr) begin
      if (sel == SEL_PA)     pa_lat_r <= wd[5:0];
      if (sel == SEL_PB)     pb_lat_r <= wd;
      if (sel == SEL_PC)     pc_lat_r <= wd;
      if (sel == SEL_DIR_A)  dir_a_r  <= wd[5:0];
      if (sel == SEL_DIR_B)  dir_b_r  <= wd;
      if (sel == SEL_DIR_C)  dir_c_r  <= wd;
      if (sel == SEL_OPTION) opt_r    <= wd;
      if (sel == SEL_ANALOG) an_r     <= wd & `ANALOG_WMASK;
    end
  end

  // ****************************************
  // change detect on port b bits 7..4
  // ****************************************

  // outputs are masked out by their direction bit
  assign mismatch = |((pb_sync[7:4] ^ ref_r) & dir_b_r[7:4]);

  // set beats a software clear in the same cycle
  assign flag_nxt = mismatch ? 1'b1 :
                    (wr && sel == SEL_INTCTL) ? wd[`INT_FLAG] : flag_r;

  // polling here would refresh the reference and hide edges
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      flag_r <= 1'b0;
      ref_r  <= 4'h0;
    end else begin
      flag_r <= flag_nxt;
      if (acc && sel == SEL_PB) ref_r <= pb_sync[7:4];
    end
  end

  // ****************************************
  // apb read path
  // ****************************************

  logic [7:0] rdata;
  logic       rerr;

  assign an_mask = analog_mask(an_r[3:0]);

  // analog pins read zero regardless of direction
  always_comb begin
    rdata = 8'h00;
    rerr  = 1'b0;
    case (sel)
      SEL_PA:     rdata = {2'b00, pa_sync & ~an_mask};
      SEL_PB:     rdata = pb_sync;
      SEL_PC:     rdata = pc_sync;
      SEL_INTCTL: rdata = {7'h00, flag_r};
      SEL_OPTION: rdata = opt_r;
      SEL_DIR_A:  rdata = {2'b00, dir_a_r};
      SEL_DIR_B:  rdata = dir_b_r;
      SEL_DIR_C:  rdata = dir_c_r;
      SEL_ANALOG: rdata = an_r;
      default:    rerr  = 1'b1;
    endcase
  end

  // answer is captured in setup, shown for one access cycle
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pready_r  <= 1'b0;
      prdata_o  <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_o  <= setup ? {24'h000000, rdata} : 32'h00000000;
      pslverr_o <= setup & rerr;
    end
  end

  assign pready_o = pready_r;

  // ****************************************
  // pin drive
  // ****************************************

  logic [5:0] pa_out_nxt;
  logic [5:0] pa_oe_n_nxt;
  logic [7:0] pb_oe_n_nxt;
  logic [7:0] pc_out_nxt;
  logic [7:0] pc_oe_n_nxt;

  // open-drain bit only ever sinks current
  always_comb begin
    pa_out_nxt  = pa_lat_r;
    pa_oe_n_nxt = dir_a_r;
    pa_out_nxt[`PA_TIMER]  = 1'b0;
    pa_oe_n_nxt[`PA_TIMER] = dir_a_r[`PA_TIMER] | pa_lat_r[`PA_TIMER];
    pb_oe_n_nxt = dir_b_r;
    pb_oe_n_nxt[`PB_PGM] = dir_b_r[`PB_PGM] | lvp_en_i;
  end

  // per-pin peripheral mux on port c
  for (genvar i = 0; i < 8; i++) begin : g_pc
    assign pc_out_nxt[i]  = pc_periph_i.sel[i] ? pc_periph_i.dout[i] : pc_lat_r[i];
    assign pc_oe_n_nxt[i] = pc_periph_i.sel[i] ? ~pc_periph_i.oe[i] : dir_c_r[i];
  end

  // pin registers; everything floats during reset
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pa_out_o    <= 6'h00;
      pa_oe_n_o   <= 6'h3F;
      pb_out_o    <= 8'h00;
      pb_oe_n_o   <= 8'hFF;
      pb_pullup_o <= 8'h00;
      pc_out_o    <= 8'h00;
      pc_oe_n_o   <= 8'hFF;
    end else begin
      pa_out_o    <= pa_out_nxt;
      pa_oe_n_o   <= pa_oe_n_nxt;
      pb_out_o    <= pb_lat_r;
      pb_oe_n_o   <= pb_oe_n_nxt;
      pb_pullup_o <= {8{~opt_r[`OPT_PULLUP_N]}} & pb_oe_n_nxt;
      pc_out_o    <= pc_out_nxt;
      pc_oe_n_o   <= pc_oe_n_nxt;
    end
  end

  // ****************************************
  // alternate functions
  // ****************************************

  // programming pins pass only while low-voltage mode is on
  always_ff @(posedge mclk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      timer_clk_o  <= 1'b0;
      ext_irq_o    <= 1'b0;
      ext_edge_o   <= 1'b1;
      prog_mode_o  <= 1'b0;
      prog_clock_o <= 1'b0;
      prog_data_o  <= 1'b0;
      smbus_lvl_o  <= 1'b0;
      wake_o       <= 1'b0;
    end else begin
      timer_clk_o  <= pa_sync[`PA_TIMER];
      ext_irq_o    <= pb_sync[`PB_EXT];
      ext_edge_o   <= opt_r[`OPT_EDGE];
      prog_mode_o  <= lvp_en_i & pb_sync[`PB_PGM];
      prog_clock_o <= lvp_en_i & pb_sync[`PB_PGC];
      prog_data_o  <= lvp_en_i & pb_sync[`PB_PGD];
      smbus_lvl_o  <= i2c_en_i & smbus_sel_i;
      wake_o       <= flag_r;
    end
  end

  // ****************************************
  // assertions
  // ****************************************

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_r);

  a_dir_reset: assert property ($rose(rst_n_r) |->
    dir_a_r == `RST_DIR_A && dir_b_r == `RST_DIR_B && dir_c_r == `RST_DIR_C)
    else $error("direction not all inputs after reset");
  a_pa_dir_pin: assert property (wr && sel == SEL_DIR_A |=> ##1
    pa_oe_n_o[3:0] == $past(wd[3:0], 2))
    else $error("port a enable does not follow direction");
  a_pa_upper: assert property (pready_o && (sel == SEL_PA ||
    sel == SEL_DIR_A) |-> prdata_o[7:6] == 2'b00)
    else $error("port a upper bits not zero");
  a_od_low: assert property (!pa_oe_n_o[`PA_TIMER] |->
    !pa_out_o[`PA_TIMER])
    else $error("open drain bit driven high");
  a_pullup_off: assert property (wr && sel == SEL_OPTION &&
    wd[`OPT_PULLUP_N] |=> ##1 pb_pullup_o == 8'h00)
    else $error("pull-ups stay on after disable");
  a_out_no_pullup: assert property ((pb_pullup_o & ~pb_oe_n_o) == 8'h00)
    else $error("pull-up on a driven pin");
  a_out_excluded: assert property (dir_b_r[7:4] == 4'h0 |-> !mismatch)
    else $error("output pin joined change compare");
  a_flag_sticks: assert property (mismatch && wr &&
    sel == SEL_INTCTL |=> flag_r)
    else $error("clear stuck over mismatch");
  a_ref_refresh: assert property (acc && sel == SEL_PB |=>
    ref_r == $past(pb_sync[7:4]))
    else $error("reference not refreshed");
  a_wake_path: assert property (mismatch |=> ##1 wake_o)
    else $error("change did not reach wake");
  a_pc_override: assert property (pc_periph_i.sel[0] &&
    !pc_periph_i.oe[0] |=> pc_oe_n_o[0])
    else $error("peripheral input override ignored");

  c_flag_set: cover property (!flag_r ##1 flag_r);
  c_pb_read: cover property (acc && !apb_i.pwrite && sel == SEL_PB);
  c_pc_drive: cover property (pc_periph_i.sel[0] && pc_periph_i.oe[0]);
  c_clear_lost: cover property (mismatch && wr && sel == SEL_INTCTL);
  c_pc_force_in: cover property (pc_periph_i.sel[0] && !pc_periph_i.oe[0]);

  // alternate-function outputs track their sources one edge late
  a_smbus_level: assert property (smbus_lvl_o == $past(i2c_en_i & smbus_sel_i))
    else $error("smbus level select does not follow enable");
  a_edge_select: assert property (ext_edge_o == $past(opt_r[`OPT_EDGE]))
    else $error("external irq edge does not follow option");

endmodule

/* File: tb/gpio_three_port_bench.sv */
// self-checking bench of the three-port gpio block
// assumes the pad model above; only the watchdog bounds an apb wait
`include "gpio_cfg.svh"
module gpio_three_port_bench
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i, arst_n_i, prdy, perr, i2c, smb, low_voltage_programming, slv, tclk, eirq, eedg;
  logic pm, pcl, pdt, wake, er;
  apb_req_t    req;
  periph_pin_t per;
  logic [31:0] prd, rd, seed, v, w, d;
  logic [5:0]  pa_i, pa_o, pa_oe, ext_a;
  logic [7:0]  pb_i, pb_o, pb_oe, pb_pu, pc_i, pc_o, pc_oe, ext_b, ext_c, eo;
  logic [7:0]  codes [4] = '{8'h00, 8'h06, 8'h04, 8'h0F};
  logic [5:0]  masks [4] = '{6'h2F, 6'h00, 6'h0B, 6'h01};
  int          fails, tests_run;
  int          shadow [int]; // model of written register values
  gpio_three_port u_gpio_three_port (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .apb_i(req),
    .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .pa_in_i(pa_i), .pa_out_o(pa_o),
    .pa_oe_n_o(pa_oe), .pb_in_i(pb_i), .pb_out_o(pb_o), .pb_oe_n_o(pb_oe),
    .pb_pullup_o(pb_pu), .pc_in_i(pc_i), .pc_out_o(pc_o), .pc_oe_n_o(pc_oe),
    .pc_periph_i(per), .i2c_en_i(i2c), .smbus_sel_i(smb), .lvp_en_i(low_voltage_programming),
    .smbus_lvl_o(slv), .timer_clk_o(tclk), .ext_irq_o(eirq), .ext_edge_o(eedg),
    .prog_mode_o(pm), .prog_clock_o(pcl), .prog_data_o(pdt), .wake_o(wake));
  pin_partner u_pin_partner (.pa_out_i(pa_o), .pa_oe_n_i(pa_oe), .pb_out_i(pb_o),
    .pb_oe_n_i(pb_oe), .pc_out_i(pc_o), .pc_oe_n_i(pc_oe), .ext_a_i(ext_a),
    .ext_b_i(ext_b), .ext_c_i(ext_c), .pa_pin_o(pa_i), .pb_pin_o(pb_i), .pc_pin_o(pc_i));
  // ********************************
  // clock, watchdog, helpers
  // ********************************
  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  // whole run is some 350 cycles; far longer means a hang
  initial begin
    #400us;
    fails++;
    wrap_up();
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [9:0] ix, input logic [7:0] dat);
    @(posedge mclk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {ix, 2'b00}, pwdata: {24'h0, dat}};
    @(posedge mclk_i);
    req.penable <= 1'b1;
    // no cycle count assumed; a missing pready is left to the watchdog
    do begin
      @(posedge mclk_i);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    req <= '0;
    if (wr) shadow[ix] = dat;
  endtask
  task automatic rdchk(input string n, input logic [9:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 8'h00);
    chk(n, rd, e);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ********************************
  // main sequence
  // ********************************
  initial begin
    seed = 32'd84099;
    req = '0;
    per = '0;
    {i2c, smb, low_voltage_programming} = 3'b000;
    ext_a = 6'h15;
    ext_b = 8'h00;
    ext_c = 8'hA5;
    arst_n_i = 1'b0;
    wt(5);
    arst_n_i <= 1'b1;
    wt(3);
    rdchk("option", `IDX_OPTION, 32'hFF);
    rdchk("dir_a", `IDX_DIR_A, 32'h3F);
    rdchk("dir_b", `IDX_DIR_B, 32'hFF);
    rdchk("dir_c", `IDX_DIR_C, 32'hFF);
    rdchk("analog", `IDX_ANALOG, 32'h00);
    rdchk("pa_reset", `IDX_PORT_A, {26'h0, ext_a & 6'h10});
    chk("pullup_reset", pb_pu, 32'h0);
    chk("oe_reset", {pa_oe, pb_oe, pc_oe}, 32'h3FFFFF);
    apb(1'b0, 10'h3FF, 8'h00);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_data", rd, 32'h0);
    $display("test reset done");
    // analog field codes decide which port a pins read zero
    for (int i = 0; i < 4; i++) begin
      ext_a <= 6'(xs());
      apb(1'b1, `IDX_ANALOG, codes[i] | 8'hC0);
      rdchk("analog_rb", `IDX_ANALOG, shadow[`IDX_ANALOG] & 32'h8F);
      rdchk("pa_digital", `IDX_PORT_A, ext_a & ~masks[i]);
    end
    apb(1'b1, `IDX_DIR_A, 8'hFF);
    rdchk("dir_a_hi", `IDX_DIR_A, 32'h3F);
    apb(1'b1, `IDX_DIR_A, 8'h00);
    for (int i = 0; i < 3; i++) begin
      d = xs();
      apb(1'b1, `IDX_PORT_A, d[7:0]);
      wt(5);
      chk("pa_out", pa_o, d & 32'h2F);
      chk("pa_oe", pa_oe, d & 32'h10);
      chk("timer_clk", tclk, d[4] & ext_a[4]);
      rdchk("pa_pins", `IDX_PORT_A, ((d & 32'h2F) | (d[4] ? ext_a & 6'h10 : 0)) & 32'h3E);
    end
    $display("test port a done");
    // option, direction and latch of port b together
    for (int i = 0; i < 5; i++) begin
      v = xs();
      low_voltage_programming <= v[24];
      apb(1'b1, `IDX_OPTION, v[7:0]);
      apb(1'b1, `IDX_DIR_B, v[15:8]);
      apb(1'b1, `IDX_PORT_B, v[23:16]);
      wt(3);
      chk("pullup", pb_pu, v[7] ? 32'h0 : {24'h0, v[15:8] | {v[24], 3'b000}});
      chk("pb_oe", pb_oe, v[15:8] | {v[24], 3'b000});
      chk("pb_out", pb_o, v[23:16]);
      chk("ext_edge", eedg, v[6]);
    end
    apb(1'b1, `IDX_DIR_B, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      ext_b <= 8'(xs());
      low_voltage_programming <= i[0];
      wt(5);
      chk("prog_pins", {pm, pcl, pdt}, {ext_b[3], ext_b[6], ext_b[7]} & {3{i[0]}});
      chk("ext_irq", eirq, ext_b[0]);
    end
    low_voltage_programming <= 1'b0;
    $display("test port b done");
    // change detect; bit 7 as output must stay out of the compare
    apb(1'b1, `IDX_DIR_B, 8'h7F);
    ext_b <= 8'h00;
    wt(5);
    apb(1'b0, `IDX_PORT_B, 8'h00);
    apb(1'b1, `IDX_INTCTL, 8'h00);
    wt(5);
    rdchk("flag_idle", `IDX_INTCTL, 32'h0);
    apb(1'b1, `IDX_PORT_B, 8'h80);
    ext_b <= 8'h02;
    wt(8);
    rdchk("flag_excl", `IDX_INTCTL, 32'h0);
    ext_b <= 8'h22;
    wt(8);
    rdchk("flag_set", `IDX_INTCTL, 32'h1);
    chk("wake", wake, 1'b1);
    apb(1'b1, `IDX_INTCTL, 8'h00);
    wt(2);
    rdchk("flag_sticks", `IDX_INTCTL, 32'h1);
    apb(1'b0, `IDX_PORT_B, 8'h00);
    apb(1'b1, `IDX_INTCTL, 8'h00);
    wt(2);
    rdchk("flag_clear", `IDX_INTCTL, 32'h0);
    chk("wake_clear", wake, 1'b0);
    $display("test change done");
    // peripheral claims on port c, random selects and enables
    for (int i = 0; i < 8; i++) begin
      v = xs();
      w = xs();
      ext_c <= v[31:24];
      per <= '{sel: v[7:0], dout: v[15:8], oe: v[23:16]};
      i2c <= w[16];
      smb <= w[17];
      apb(1'b1, `IDX_DIR_C, w[7:0]);
      apb(1'b1, `IDX_PORT_C, w[15:8]);
      wt(4);
      eo = (v[7:0] & ~v[23:16]) | (~v[7:0] & w[7:0]);
      d = (v[7:0] & v[15:8]) | (~v[7:0] & w[15:8]);
      chk("pc_out", pc_o, d);
      chk("pc_oe", pc_oe, eo);
      chk("smbus_lvl", slv, w[16] & w[17]);
      rdchk("pc_pins", `IDX_PORT_C, (~eo & d[7:0]) | (eo & ext_c));
    end
    $display("test port c done");
    wrap_up();
  end
endmodule

/* File: tb/pin_partner.sv */
// pad and keypad model for the three gpio ports
// assumes oe_n low means the block drives, else the outside drives
module pin_partner (
  input  wire logic [5:0] pa_out_i,  // port a drive value
  input  wire logic [5:0] pa_oe_n_i, // port a enable
  input  wire logic [7:0] pb_out_i,  // port b drive value
  input  wire logic [7:0] pb_oe_n_i, // port b enable
  input  wire logic [7:0] pc_out_i,  // port c drive value
  input  wire logic [7:0] pc_oe_n_i, // port c enable
  input  wire logic [5:0] ext_a_i,   // outside level, port a
  input  wire logic [7:0] ext_b_i,   // outside level, port b
  input  wire logic [7:0] ext_c_i,   // outside level, port c
  output logic      [5:0] pa_pin_o,  // resolved port a pads
  output logic      [7:0] pb_pin_o,  // resolved port b pads
  output logic      [7:0] pc_pin_o   // resolved port c pads
);
  timeunit 1ns;
  timeprecision 100ps;
  // ********************************
  // pad resolution
  // ********************************
  // keypad always drives a floated pin, so no pull-up level is modelled
  assign pa_pin_o = (~pa_oe_n_i & pa_out_i) | (pa_oe_n_i & ext_a_i);
  assign pb_pin_o = (~pb_oe_n_i & pb_out_i) | (pb_oe_n_i & ext_b_i);
  assign pc_pin_o = (~pc_oe_n_i & pc_out_i) | (pc_oe_n_i & ext_c_i);
endmodule
